/* rtl/prl_pin_remap_write_lock.v */
// Pin remap select registers with remap lock and one-way lock
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - Locked select-register writes complete normally but change nothing.
// - Remap lock is bit 13 of system config register; one blocks writes.
// - Lock bit changes only after the unlock sequence; otherwise ignored.
// - With one-way enable set, a set remap lock cannot be cleared.
// - Under one-way protection only device reset clears the lock.
// - One-way enable reads as set when unprogrammed.
// - Input select holds 4-bit selector in bits 3-0, reset zero.
// - Output select holds 4-bit selector in bits 3-0, reset zero.
// - Bits 31-4 of select registers ignore writes, read zero.
// - Output selector zero selects the null output.
// - One output select register per remappable pin.
`include "prl_consts.vh"

module prl_pin_remap_write_lock (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  input wire clk_en,
  // Register port
  input wire [`PRL_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // System lock controller and configuration word
  input wire unlock_ok,
  input wire [31:0] device_config_word_three,
  // Remap selectors
  output wire [`PRL_NUM_IN*`PRL_SEL_W-1:0] in_sel,
  output wire [`PRL_NUM_OUT*`PRL_SEL_W-1:0] out_sel,
  output wire [`PRL_NUM_OUT-1:0] out_connected,
  output wire remap_lock
);

  // Capture sequence states for the one-way enable
  localparam CAP_SYNC = 2'b00;
  localparam CAP_WAIT = 2'b01;
  localparam CAP_LOAD = 2'b10;
  localparam CAP_DONE = 2'b11;

  // Bank codes for the read select
  localparam BANK_NONE = 2'b00;
  localparam BANK_CFG = 2'b01;
  localparam BANK_IN = 2'b10;
  localparam BANK_OUT = 2'b11;

  // Register counts and word widths
  localparam NUM_IN = `PRL_NUM_IN;
  localparam NUM_OUT = `PRL_NUM_OUT;
  localparam SEL_W = `PRL_SEL_W;
  localparam AW = `PRL_ADDR_W;
  localparam WORD_W = 32;
  localparam PAD_W = WORD_W - SEL_W;

  // Word index decode within a bank
  function hit;
    input [AW-1:0] a;
    input [AW-1:0] base;
    input integer idx;
    begin
      hit = (a == base + idx[AW-1:0] * 8'h04);
    end
  endfunction

  // Selector placed in a read word, upper bits zero
  function [WORD_W-1:0] sel_word;
    input [SEL_W-1:0] sel;
    begin
      sel_word = {{PAD_W{1'b0}}, sel};
    end
  endfunction

  // Lock bit placed in a config read word
  function [WORD_W-1:0] lock_word;
    input lock;
    begin
      lock_word = {WORD_W{1'b0}};
      lock_word[`PRL_LOCK_BIT] = lock;
    end
  endfunction

  // Bus requests taken while the clock enable is high
  wire wr_take;
  wire rd_take;
  wire [SEL_W-1:0] wr_sel;

  // Configuration word synchroniser and capture
  reg cfg_sync1_q;
  reg cfg_sync2_q;
  reg [1:0] cap_state_q;
  reg [1:0] cap_state_d;
  reg cap_load;
  reg one_way_q;

  // Lock bit
  reg remap_lock_q;
  reg remap_lock_d;
  wire cfg_wr;
  wire new_lock;
  wire lock_set_req;
  wire lock_clear_req;
  wire lock_clear_refused;

  // Selector storage and decode
  reg [SEL_W-1:0] in_q [0:NUM_IN-1];
  reg [SEL_W-1:0] out_q [0:NUM_OUT-1];
  wire [NUM_IN-1:0] in_hit;
  wire [NUM_OUT-1:0] out_hit;
  wire [NUM_IN-1:0] in_we;
  wire [NUM_OUT-1:0] out_we;
  wire cfg_hit;
  wire sel_wr_open;

  // Read path, one chain of words per selector bank
  wire [WORD_W-1:0] in_word [0:NUM_IN-1];
  wire [WORD_W-1:0] out_word [0:NUM_OUT-1];
  wire [WORD_W-1:0] in_chain [0:NUM_IN];
  wire [WORD_W-1:0] out_chain [0:NUM_OUT];
  wire [WORD_W-1:0] cfg_word;
  wire in_bank_hit;
  wire out_bank_hit;
  reg [1:0] rd_bank;
  reg [WORD_W-1:0] rd_d;

  assign wr_take = clk_en && reg_wr;
  assign rd_take = clk_en && reg_rd;
  assign wr_sel = reg_wdata[SEL_W-1:0];
  assign remap_lock = remap_lock_q;
  assign cfg_hit = reg_addr == `PRL_OFF_CFG;
  assign cfg_wr = wr_take && cfg_hit;
  assign new_lock = reg_wdata[`PRL_LOCK_BIT];
  assign sel_wr_open = wr_take && !remap_lock_q;

  // Two flip-flops before the configuration bit is used
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_sync1_q <= 1'b1;
      cfg_sync2_q <= 1'b1;
    end else if (clk_en) begin
      cfg_sync1_q <= device_config_word_three[`PRL_ONE_WAY_BIT];
      cfg_sync2_q <= cfg_sync1_q;
    end
  end

  // Capture sequence: let the synchroniser fill, then load once
  always @* begin
    cap_state_d = cap_state_q;
    case (cap_state_q)
      CAP_SYNC: begin
        cap_state_d = CAP_WAIT;
      end
      CAP_WAIT: begin
        cap_state_d = CAP_LOAD;
      end
      CAP_LOAD: begin
        cap_state_d = CAP_DONE;
      end
      CAP_DONE: begin
        cap_state_d = CAP_DONE;
      end
      default: begin
        cap_state_d = CAP_SYNC;
      end
    endcase
  end

  // Capture state register
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cap_state_q <= CAP_SYNC;
    end else if (clk_en) begin
      cap_state_q <= cap_state_d;
    end
  end

  // Load strobe decoded from the capture state
  always @* begin
    case (cap_state_q)
      CAP_LOAD: begin
        cap_load = 1'b1;
      end
      default: begin
        cap_load = 1'b0;
      end
    endcase
  end

  // One-way enable stays set until the captured value arrives
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      one_way_q <= 1'b1;
    end else if (clk_en && cap_load) begin
      one_way_q <= cfg_sync2_q;
    end
  end

  // Lock changes need the unlock permission
  assign lock_set_req = cfg_wr && unlock_ok && new_lock;
  assign lock_clear_req = cfg_wr && unlock_ok && !new_lock;

  // Clearing a set lock is refused under one-way protection
  assign lock_clear_refused = lock_clear_req && one_way_q &&
                              remap_lock_q;

  // Remap lock next value
  always @* begin
    remap_lock_d = remap_lock_q;
    if (lock_set_req) begin
      remap_lock_d = 1'b1;
    end else if (lock_clear_req) begin
      if (lock_clear_refused) begin
        remap_lock_d = remap_lock_q;
      end else begin
        remap_lock_d = 1'b0;
      end
    end
  end

  // Remap lock register
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      remap_lock_q <= 1'b0;
    end else if (clk_en) begin
      remap_lock_q <= remap_lock_d;
    end
  end

  // Per-register address decode and write enables
  genvar g;
  generate
    for (g = 0; g < NUM_IN; g = g + 1) begin : g_in_dec
      assign in_hit[g] = hit(reg_addr, `PRL_OFF_IN_BASE, g);
      assign in_we[g] = sel_wr_open && in_hit[g];
    end
    for (g = 0; g < NUM_OUT; g = g + 1) begin : g_out_dec
      assign out_hit[g] = hit(reg_addr, `PRL_OFF_OUT_BASE, g);
      assign out_we[g] = sel_wr_open && out_hit[g];
    end
  endgenerate

  // Input selectors, one per peripheral input
  generate
    for (g = 0; g < NUM_IN; g = g + 1) begin : g_in
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          in_q[g] <= `PRL_SEL_RESET;
        end else if (in_we[g]) begin
          in_q[g] <= wr_sel;
        end
      end
      assign in_sel[g*SEL_W +: SEL_W] = in_q[g];
      assign in_word[g] = sel_word(in_q[g]);
    end
  endgenerate

  // Output selectors, one per remappable pin
  generate
    for (g = 0; g < NUM_OUT; g = g + 1) begin : g_out
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          out_q[g] <= `PRL_SEL_RESET;
        end else if (out_we[g]) begin
          out_q[g] <= wr_sel;
        end
      end
      assign out_sel[g*SEL_W +: SEL_W] = out_q[g];
      assign out_word[g] = sel_word(out_q[g]);
      assign out_connected[g] = out_q[g] != `PRL_NULL_OUT;
    end
  endgenerate

  // Bank read chains: each register passes its word when addressed
  assign in_chain[0] = {WORD_W{1'b0}};
  assign out_chain[0] = {WORD_W{1'b0}};
  generate
    for (g = 0; g < NUM_IN; g = g + 1) begin : g_in_rd
      assign in_chain[g+1] = in_hit[g] ? in_word[g] : in_chain[g];
    end
    for (g = 0; g < NUM_OUT; g = g + 1) begin : g_out_rd
      assign out_chain[g+1] = out_hit[g] ? out_word[g] : out_chain[g];
    end
  endgenerate
  assign in_bank_hit = |in_hit;
  assign out_bank_hit = |out_hit;

  // Config register read word
  assign cfg_word = lock_word(remap_lock_q);

  // Bank addressed by the read
  always @* begin
    rd_bank = BANK_NONE;
    if (cfg_hit) begin
      rd_bank = BANK_CFG;
    end else if (in_bank_hit) begin
      rd_bank = BANK_IN;
    end else if (out_bank_hit) begin
      rd_bank = BANK_OUT;
    end
  end

  // Read data select, unmapped addresses read zero
  always @* begin
    case (rd_bank)
      BANK_CFG: begin
        rd_d = cfg_word;
      end
      BANK_IN: begin
        rd_d = in_chain[NUM_IN];
      end
      BANK_OUT: begin
        rd_d = out_chain[NUM_OUT];
      end
      default: begin
        rd_d = {WORD_W{1'b0}};
      end
    endcase
  end

  // Read data, one cycle after the strobe, zero after other enabled cycles, held while clk_en is low
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= {WORD_W{1'b0}};
    end else if (clk_en) begin
      if (rd_take) begin
        reg_rdata <= rd_d;
      end else begin
        reg_rdata <= {WORD_W{1'b0}};
      end
    end
  end

endmodule

/* rtl/prl_consts.vh */
// Constants for the pin remap write lock block
`ifndef PRL_CONSTS_VH
`define PRL_CONSTS_VH
`define PRL_NUM_IN 8
`define PRL_NUM_OUT 8
`define PRL_SEL_W 4
`define PRL_ADDR_W 8
`define PRL_OFF_CFG 8'h00
`define PRL_OFF_IN_BASE 8'h40
`define PRL_OFF_OUT_BASE 8'h80
`define PRL_LOCK_BIT 13
`define PRL_ONE_WAY_BIT 29
`define PRL_SEL_RESET 4'h0
`define PRL_NULL_OUT 4'h0
`endif

/* test/prl_props.sv */
// Assertions on the remap lock block ports
`timescale 1ns/1ps
module prl_props (
  input wire sys_clk, rst, clk_en, reg_wr, reg_rd, unlock_ok, remap_lock,
  input wire [7:0] reg_addr, out_connected,
  input wire [31:0] reg_wdata, reg_rdata, device_config_word_three,
  input wire [31:0] in_sel, out_sel
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_locked_in_hold: assert property (remap_lock |=> $stable(in_sel))
    else $error("in_sel moved");
  a_open_in_write: assert property (reg_wr && clk_en && !remap_lock &&
    reg_addr == 8'h40 |=> in_sel[3:0] == $past(reg_wdata[3:0]))
    else $error("in_sel not written");
  a_one_way_hold: assert property (remap_lock &&
    device_config_word_three[29] |=> remap_lock) else $error("lock cleared");
  a_no_unlock: assert property (!unlock_ok |=> $stable(remap_lock))
    else $error("lock moved");
  a_cfg_read: assert property (reg_rd && clk_en && reg_addr == 8'h00
    |=> reg_rdata == ($past(remap_lock) ? 32'h2000 : 32'h0))
    else $error("cfg read wrong");
  a_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 32'h0)
    else $error("rdata not idle");
  a_upper_zero: assert property (reg_rd && clk_en |=>
    reg_rdata[31:14] == 0 && reg_rdata[12:4] == 0)
    else $error("upper bits set");
  a_null_out: assert property (out_connected ==
    {|out_sel[31:28], |out_sel[27:24], |out_sel[23:20], |out_sel[19:16],
     |out_sel[15:12], |out_sel[11:8], |out_sel[7:4], |out_sel[3:0]})
    else $error("null output wrong");
endmodule
bind prl_pin_remap_write_lock prl_props prl_props_i (.*);

/* test/testbench.sv */
// Self-checking bench for the remap lock block
`timescale 1ns/1ps
module testbench;
  reg sys_clk = 0, rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, unlock_ok = 0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0, device_config_word_three = 32'h0;
  wire [31:0] reg_rdata, in_sel, out_sel;
  wire [7:0] out_connected;
  wire remap_lock;
  integer errors = 0, cmp_count = 0, cyc = 0;
  always #25 sys_clk = ~sys_clk;
  prl_pin_remap_write_lock prl_pin_remap_write_lock_i (.*);
  task wr(input [7:0] a, input [31:0] d);
    @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk) reg_rd <= 1'b0;
    @(negedge sys_clk) cmp_count = cmp_count + 1;
    if (reg_rdata !== e) begin
      errors = errors + 1;
      $display("wrong value reg %h exp %h seen %h", a, e, reg_rdata);
    end
  endtask
  task chk(input [8*16-1:0] n, input [31:0] e, input [31:0] s);
    cmp_count = cmp_count + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("wrong value %0s exp %h seen %h", n, e, s);
    end
  endtask
  task do_rst(input [31:0] c);
    rst <= 1'b1;
    device_config_word_three <= c;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
  endtask
  task report_and_stop;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      report_and_stop;
    end
  end
  initial begin
    do_rst(32'h0);
    @(negedge sys_clk);
    chk("out_sel", 32'h0, out_sel);
    chk("out_connected", 32'h0, {24'h0, out_connected});
    wr(8'h44, 32'hffffffff);
    rd(8'h44, 32'hf);
    wr(8'h80, 32'h5);
    rd(8'h80, 32'h5);
    chk("in_sel", 32'hf0, in_sel);
    chk("out_sel", 32'h5, out_sel);
    chk("out_connected", 32'h1, {24'h0, out_connected});
    wr(8'h00, 32'h2000);
    rd(8'h00, 32'h0);
    unlock_ok <= 1'b1;
    wr(8'h00, 32'h2000);
    rd(8'h00, 32'h2000);
    chk("remap_lock", 32'h1, {31'h0, remap_lock});
    wr(8'h44, 32'h3);
    rd(8'h44, 32'hf);
    chk("in_sel", 32'hf0, in_sel);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h3c, 32'h0);
    do_rst(32'hffffffff);
    wr(8'h00, 32'h2000);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h2000);
    chk("remap_lock", 32'h1, {31'h0, remap_lock});
    do_rst(32'hffffffff);
    wr(8'h84, 32'h9);
    rd(8'h84, 32'h9);
    chk("out_sel", 32'h90, out_sel);
    chk("out_connected", 32'h2, {24'h0, out_connected});
    report_and_stop;
  end
endmodule
